/* logic/ipc_pkg.sv */
// constants for the idle and power-down controller
package ipc_pkg;
    localparam logic [7:0] IPC_ADDR_PWR = 8'h87;
    localparam logic [7:0] IPC_PWR_RESET = 8'h00;
    localparam int IPC_BIT_DOUBLE = 7;
    localparam int IPC_BIT_RSV_HI = 6;
    localparam int IPC_BIT_RSV_LO = 4;
    localparam int IPC_BIT_FLAG_HI = 3;
    localparam int IPC_BIT_FLAG_LO = 2;
    localparam int IPC_BIT_PDOWN = 1;
    localparam int IPC_BIT_IDLE = 0;
    localparam logic [7:0] IPC_WR_MASK = 8'h8f;
    // strong pull-up lasts two oscillator periods
    localparam int IPC_PULLUP_OSC = 2;
    // reset lasts 2 machine cycles of 12 oscillator periods
    localparam int IPC_RESET_MC = 2;
    localparam int IPC_OSC_PER_MC = 12;
    localparam int IPC_RESET_OSC = IPC_RESET_MC * IPC_OSC_PER_MC;
    typedef enum logic [1:0] {IPC_RUN, IPC_IDLE, IPC_PDOWN} ipc_mode_e;
endpackage

/* logic/ipc_pullup.sv */
// per-pin strong pull-up pulse timer
`timescale 1ns/1ps
`default_nettype none
module ipc_pullup
    import ipc_pkg::*;
#(
    parameter int PULSE = IPC_PULLUP_OSC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // oscillator period enable
    input wire logic osc_en,
    // latch bit and address override
    input wire logic latch_bit,
    input wire logic addr_mode,
    input wire logic addr_bit,
    // strong pull-up request
    output logic strong_pullup
);
    if (PULSE < 1 || PULSE > 7) begin : g_bad_pulse
        $error("ipc_pullup: PULSE out of range");
    end
    logic prev_ff, nxt_prev;
    logic [2:0] cnt_ff, nxt_cnt;
    logic pu_ff, nxt_pu;
    always_comb begin
        nxt_prev = prev_ff;
        nxt_cnt = cnt_ff;
        if (osc_en) begin
            nxt_prev = latch_bit;
            if (latch_bit && !prev_ff) begin
                nxt_cnt = 3'(PULSE); // R19
            end else if (cnt_ff != 3'h0) begin
                nxt_cnt = cnt_ff - 3'h1;
            end
        end
        // address bits at 1 keep the strong drive for the whole access
        nxt_pu = addr_mode ? addr_bit : (nxt_cnt != 3'h0); // R20
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_ff <= 1'b0;
            cnt_ff <= 3'h0;
            pu_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
            cnt_ff <= nxt_cnt;
            pu_ff <= nxt_pu;
        end
    end
    assign strong_pullup = pu_ff;
endmodule
`default_nettype wire

/* logic/ipc_top.sv */
// idle and power-down clock controller with its control register
//
// Contract
// R01: power-down stops the oscillator; no internal clock runs.
// R02: idle gates the CPU clock only; peripherals keep their clock.
// R03: control register sits at special address 87h, byte access only.
// R04: bit 7 doubles serial baud rate in modes 1, 2, 3.
// R05: software never writes 1 to bits 6..4; they read undefined.
// R06: bits 3 and 2 are plain software flags without hardware effect; code drives them onto the strobe_force output.
// R07: writing bit 1 enters power-down; interrupt or reset clears it.
// R08: writing bit 0 enters idle; any enabled interrupt clears it.
// R09: both requests in one write enter power-down, not idle.
// R10: reset loads zero in all bits; bits 6..4 undefined.
// R11: idle-setting write is the last instruction; all state kept.
// R12: interrupt ending idle is serviced, then code resumes after it.
// R13: reset ends idle; two machine cycles, 24 oscillator periods, suffice.
// R14: power-down-setting write is the last instruction before stopping.
// R15: memory and registers kept in power-down; reset reinitialises registers.
// R16: reset source holds reset until the oscillator is stable.
// R17: power-down from external code drives port 2 from its latch.
// R18: strobes high in idle, low in power-down; port pins per mode.
// R19: 0-to-1 latch change enables strong pull-up two oscillator periods.
// R20: port 2 address bits at 1 keep strong pull-up whole access.
// R21: oscillator input divided by two before clock generation.
// R22: fully static; clock may stop without losing state.
// R23: CPU clock gate changes only while the divided clock is low.
`timescale 1ns/1ps
`default_nettype none
module ipc_top
    import ipc_pkg::*;
#(
    parameter int PULSE = IPC_PULLUP_OSC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // oscillator pin and reset pin, asynchronous
    input wire logic osc_in,
    input wire logic reset_pin,
    // special function register access from the core
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // interrupt logic
    input wire logic irq_enabled,
    // program memory source and port latches
    input wire logic ext_code,
    input wire logic ext_access,
    input wire logic [7:0] addr_hi,
    input wire logic [7:0] port_hi_latch,
    input wire logic [7:0] port1_latch,
    input wire logic [7:0] port3_latch,
    // clock enables
    output logic osc_out,
    output logic osc_run,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    // mode and register outputs
    output logic baud_double,
    output logic in_idle,
    output logic in_pdown,
    output logic core_reset,
    output logic [7:0] strobe_force,
    output logic [7:0] port_hi_out,
    output logic port0_float,
    output logic strobe_hold_hi,
    output logic strobe_hold_lo,
    output logic [7:0] strong_pullup_p1,
    output logic [7:0] strong_pullup_port_hi,
    output logic [7:0] strong_pullup_p3
);
    // pull-up timer counts in three bits
    if (PULSE < 1 || PULSE > 7) begin : g_bad_pulse
        $error("ipc_top: PULSE out of range");
    end
    // two-flop synchronisers on the pins
    logic osc_s1_ff, osc_s2_ff, rst_s1_ff, rst_s2_ff;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            osc_s1_ff <= osc_in;
            osc_s2_ff <= osc_s1_ff;
            rst_s1_ff <= reset_pin;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    // state registers
    logic osc_prev_ff, nxt_osc_prev;
    logic div_ff, nxt_div;
    logic [7:0] pwr_ff, nxt_pwr;
    ipc_mode_e mode_ff, nxt_mode;
    logic gate_ff, nxt_gate;
    logic [4:0] rst_cnt_ff, nxt_rst_cnt;
    logic core_rst_ff, nxt_core_rst;
    logic osc_en_ff, nxt_osc_en;
    logic [7:0] ph_out_ff, nxt_ph_out;
    logic p0f_ff, nxt_p0f, shi_ff, nxt_shi, slo_ff, nxt_slo;
    logic run_ff, nxt_run, in_idle_ff, nxt_in_idle, in_pdown_ff, nxt_in_pdown;
    logic cpu_en_ff, nxt_cpu_en, per_en_ff, nxt_per_en;
    logic osc_edge, pwr_hit, hw_reset;

    always_comb begin
        // an oscillator period is one rising edge of the synchronised pin
        osc_edge = osc_s2_ff && !osc_prev_ff && (mode_ff != IPC_PDOWN); // R01
        nxt_osc_prev = osc_s2_ff;
        nxt_osc_en = osc_edge;
        nxt_div = osc_edge ? !div_ff : div_ff; // R21
        pwr_hit = sfr_wr && (sfr_addr == IPC_ADDR_PWR); // R03
        // reset completes after 24 oscillator periods of reset pin high
        nxt_rst_cnt = rst_cnt_ff;
        if (!rst_s2_ff) begin
            nxt_rst_cnt = 5'h0;
        end else if (osc_edge && rst_cnt_ff != 5'(IPC_RESET_OSC)) begin
            nxt_rst_cnt = rst_cnt_ff + 5'h1;
        end
        hw_reset = (rst_cnt_ff == 5'(IPC_RESET_OSC)); // R13
        // in power-down no oscillator edges arrive: the pin level resets
        if (mode_ff == IPC_PDOWN && rst_s2_ff) begin
            hw_reset = 1'b1; // R15
        end
        nxt_core_rst = hw_reset;
        nxt_pwr = pwr_ff;
        if (hw_reset) begin
            nxt_pwr = IPC_PWR_RESET; // R10 R15
        end else if (pwr_hit) begin
            nxt_pwr = sfr_wdata & IPC_WR_MASK; // R05 R06 R04
        end else if (irq_enabled) begin
            nxt_pwr[IPC_BIT_PDOWN] = 1'b0; // R07
            nxt_pwr[IPC_BIT_IDLE] = 1'b0; // R08 R12
        end
        // power-down wins over idle
        if (nxt_pwr[IPC_BIT_PDOWN]) begin
            nxt_mode = IPC_PDOWN; // R09 R14
        end else if (nxt_pwr[IPC_BIT_IDLE]) begin
            nxt_mode = IPC_IDLE; // R11
        end else begin
            nxt_mode = IPC_RUN;
        end
        // cpu gate only changes while the divided clock is low
        nxt_gate = gate_ff;
        if (!div_ff) begin
            nxt_gate = (nxt_mode == IPC_RUN); // R23 R02
        end
        // a frozen core makes no access: only external idle shows the address
        nxt_ph_out = (ext_access && nxt_mode == IPC_RUN) ? addr_hi : port_hi_latch; // R17
        if (nxt_mode == IPC_IDLE && ext_code) begin
            nxt_ph_out = addr_hi; // R18
        end
        nxt_p0f = ext_code && (nxt_mode != IPC_RUN);
        nxt_shi = (nxt_mode == IPC_IDLE); // R18
        nxt_slo = (nxt_mode == IPC_PDOWN); // R18
        // registered copies so every output leaves a flop
        nxt_run = (nxt_mode != IPC_PDOWN); // R01
        nxt_in_idle = (nxt_mode == IPC_IDLE);
        nxt_in_pdown = (nxt_mode == IPC_PDOWN);
        nxt_per_en = osc_edge && !nxt_div; // R02
        nxt_cpu_en = osc_edge && !nxt_div && nxt_gate; // R23
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc_prev_ff <= 1'b0;
            div_ff <= 1'b0;
            pwr_ff <= IPC_PWR_RESET;
            mode_ff <= IPC_RUN;
            gate_ff <= 1'b1;
            rst_cnt_ff <= 5'h0;
            core_rst_ff <= 1'b0;
            osc_en_ff <= 1'b0;
            ph_out_ff <= 8'hff;
            p0f_ff <= 1'b0;
            shi_ff <= 1'b0;
            slo_ff <= 1'b0;
            run_ff <= 1'b1;
            in_idle_ff <= 1'b0;
            in_pdown_ff <= 1'b0;
            cpu_en_ff <= 1'b0;
            per_en_ff <= 1'b0;
        end else begin
            osc_prev_ff <= nxt_osc_prev;
            div_ff <= nxt_div;
            pwr_ff <= nxt_pwr;
            mode_ff <= nxt_mode;
            gate_ff <= nxt_gate;
            rst_cnt_ff <= nxt_rst_cnt;
            core_rst_ff <= nxt_core_rst;
            osc_en_ff <= nxt_osc_en;
            ph_out_ff <= nxt_ph_out;
            p0f_ff <= nxt_p0f;
            shi_ff <= nxt_shi;
            slo_ff <= nxt_slo;
            run_ff <= nxt_run;
            in_idle_ff <= nxt_in_idle;
            in_pdown_ff <= nxt_in_pdown;
            cpu_en_ff <= nxt_cpu_en;
            per_en_ff <= nxt_per_en;
        end
    end

    // strong pull-up timers, one per pin of ports 1, 2 and 3
    logic [23:0] pu_all;
    logic [23:0] latch_all;
    assign latch_all = {port3_latch, ph_out_ff, port1_latch};
    genvar gi;
    generate
        for (gi = 0; gi < 24; gi++) begin : g_pu
            ipc_pullup #(.PULSE(PULSE)) u_pu (
                .clk(clk),
                .nrst(nrst),
                .osc_en(osc_en_ff),
                .latch_bit(latch_all[gi]),
                .addr_mode((gi >= 8 && gi < 16) && ext_access && mode_ff == IPC_RUN),
                .addr_bit(latch_all[gi]),
                .strong_pullup(pu_all[gi])
            );
        end
    endgenerate

    // all outputs straight from flops; static design keeps state when clk stops
    assign osc_out = div_ff; // R22
    assign osc_run = run_ff;
    assign cpu_clk_en = cpu_en_ff;
    assign periph_clk_en = per_en_ff; // R02
    assign baud_double = pwr_ff[IPC_BIT_DOUBLE]; // R04
    assign sfr_rdata = pwr_ff;
    assign in_idle = in_idle_ff;
    assign in_pdown = in_pdown_ff;
    assign core_reset = core_rst_ff;
    assign strobe_force = pwr_ff;
    assign port_hi_out = ph_out_ff;
    assign port0_float = p0f_ff;
    assign strobe_hold_hi = shi_ff;
    assign strobe_hold_lo = slo_ff;
    assign strong_pullup_p1 = pu_all[7:0];
    assign strong_pullup_port_hi = pu_all[15:8];
    assign strong_pullup_p3 = pu_all[23:16];

    // assertions
    property p_pdown_wins;
        @(posedge clk) disable iff (!nrst)
        (pwr_hit && sfr_wdata[IPC_BIT_PDOWN] && sfr_wdata[IPC_BIT_IDLE] && !hw_reset)
            |=> (mode_ff == IPC_PDOWN);
    endproperty
    a_pdown_wins: assert property (p_pdown_wins) else $error("idle won over power-down"); // R09
    property p_irq_wake;
        @(posedge clk) disable iff (!nrst)
        (irq_enabled && !pwr_hit && mode_ff == IPC_IDLE) |=> (mode_ff == IPC_RUN);
    endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("interrupt did not end idle"); // R08
    property p_pdown_no_osc;
        @(posedge clk) disable iff (!nrst)
        (mode_ff == IPC_PDOWN) |-> !osc_run ##1 (!periph_clk_en && !cpu_clk_en);
    endproperty
    a_pdown_no_osc: assert property (p_pdown_no_osc) else $error("clock ran in power-down"); // R01
    property p_gate_low;
        @(posedge clk) disable iff (!nrst)
        $changed(gate_ff) |-> !$past(div_ff);
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("gate changed while clock high"); // R23
    property p_strobes;
        @(posedge clk) disable iff (!nrst)
        (pwr_ff[IPC_BIT_IDLE] && !pwr_ff[IPC_BIT_PDOWN])
            |-> (in_idle && strobe_hold_hi && !strobe_hold_lo);
    endproperty
    a_strobes: assert property (p_strobes) else $error("idle strobe level wrong"); // R18
    property p_reserved;
        @(posedge clk) disable iff (!nrst)
        pwr_hit |=> (pwr_ff[IPC_BIT_RSV_HI:IPC_BIT_RSV_LO] == 3'h0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits stored"); // R05
    property p_baud;
        @(posedge clk) disable iff (!nrst)
        (pwr_hit && !hw_reset) |=> (baud_double == $past(sfr_wdata[IPC_BIT_DOUBLE]));
    endproperty
    a_baud: assert property (p_baud) else $error("baud double not stored"); // R04
    property p_reset_clear;
        @(posedge clk) disable iff (!nrst)
        hw_reset |=> (pwr_ff == IPC_PWR_RESET);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left register set"); // R10
    property p_pdown_pins;
        @(posedge clk) disable iff (!nrst)
        pwr_ff[IPC_BIT_PDOWN] |-> (in_pdown && strobe_hold_lo && !strobe_hold_hi);
    endproperty
    a_pdown_pins: assert property (p_pdown_pins) else $error("power-down strobe level wrong"); // R18
    property p_pdown_wake;
        @(posedge clk) disable iff (!nrst)
        (irq_enabled && !pwr_hit && mode_ff == IPC_PDOWN) |=> (!in_pdown && osc_run);
    endproperty
    a_pdown_wake: assert property (p_pdown_wake) else $error("interrupt did not end power-down"); // R07
    property p_port_latch;
        @(posedge clk) disable iff (!nrst)
        in_pdown |-> (port_hi_out == $past(port_hi_latch));
    endproperty
    a_port_latch: assert property (p_port_latch) else $error("port high not from latch"); // R17
    property p_idle_gate;
        @(posedge clk) disable iff (!nrst)
        (mode_ff == IPC_IDLE && !div_ff && !irq_enabled && !pwr_hit && !hw_reset) |=> !gate_ff;
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("cpu gate open in idle"); // R02
endmodule
`default_nettype wire

/* tb/ipc_osc_model.sv */
// oscillator model that stops while the controller holds it in power-down
`timescale 1ns/1ps
`default_nettype none
module ipc_osc_model #(
    parameter int HALF = 16
) (
    // run request and oscillator pin
    input wire logic osc_run,
    output logic osc_in
);
    initial begin
        osc_in = 1'b0;
        forever begin
            #(HALF);
            osc_in = osc_run ? ~osc_in : 1'b0;
        end
    end
endmodule
`default_nettype wire

/* tb/tb_idle_powerdown_control.sv */
// self-checking bench of the idle and power-down controller
`timescale 1ns/1ps
`default_nettype none
module tb_idle_powerdown_control;
    import ipc_pkg::*;
    logic clk, nrst, osc_in, reset_pin, sfr_wr, irq_enabled, ext_code, ext_access;
    logic [7:0] sfr_addr, sfr_wdata, addr_hi, port_hi_latch, port1_latch, port3_latch;
    logic [7:0] sfr_rdata, strobe_force, port_hi_out, pu1, pu2, pu3;
    logic osc_out, osc_run, cpu_en, per_en, baud_double, in_idle, in_pdown, core_reset;
    logic port0_float, hold_hi, hold_lo;
    logic [7:0] modes [5] = '{8'h80, 8'h0c, 8'h01, 8'h02, 8'h03};
    int errors = 0, checks_done = 0, seed = 84, pwr = 0, n_cpu, n_per, n_osc, i;
    // oscillator period in clk cycles for the model's 16 ns half period
    localparam int OSC_CLK = 8;

    ipc_osc_model osc_u (.osc_run(osc_run), .osc_in(osc_in));
    ipc_top dut_u (.clk(clk), .nrst(nrst), .osc_in(osc_in), .reset_pin(reset_pin),
        .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .irq_enabled(irq_enabled), .ext_code(ext_code), .ext_access(ext_access),
        .addr_hi(addr_hi), .port_hi_latch(port_hi_latch), .port1_latch(port1_latch),
        .port3_latch(port3_latch), .osc_out(osc_out), .osc_run(osc_run),
        .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .baud_double(baud_double),
        .in_idle(in_idle), .in_pdown(in_pdown), .core_reset(core_reset),
        .strobe_force(strobe_force), .port_hi_out(port_hi_out), .port0_float(port0_float),
        .strobe_hold_hi(hold_hi), .strobe_hold_lo(hold_lo), .strong_pullup_p1(pu1),
        .strong_pullup_port_hi(pu2), .strong_pullup_p3(pu3));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // byte write; the model keeps only writable bits
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        @(negedge clk);
        sfr_wr = 1'b0;
        if (a == IPC_ADDR_PWR) begin
            pwr = d & IPC_WR_MASK;
        end
        @(negedge clk);
    endtask

    task automatic irq;
        @(negedge clk);
        irq_enabled = 1'b1;
        @(negedge clk);
        irq_enabled = 1'b0;
        pwr = pwr & 8'hfc;
        @(negedge clk);
    endtask

    task automatic cmp;
        logic idle, pdn;
        idle = pwr[0] && !pwr[1];
        pdn = pwr[1];
        check("pwr_reg", sfr_rdata & IPC_WR_MASK, pwr[7:0]);
        check("strobe_force", strobe_force, pwr[7:0]);
        check("baud_double", baud_double, pwr[7]);
        check("in_idle", in_idle, idle);
        check("in_pdown", in_pdown, pdn);
        check("strobe_hi", hold_hi, idle);
        check("strobe_lo", hold_lo, pdn);
        check("port0_float", port0_float, ext_code && (idle || pdn));
        if (pdn) check("port_hi", port_hi_out, port_hi_latch);
        if (idle) check("port_hi", port_hi_out, ext_code ? addr_hi : port_hi_latch);
        n_cpu = 0;
        n_per = 0;
        n_osc = 0;
        repeat (16) @(negedge clk);
        repeat (64) begin
            @(negedge clk);
            n_cpu += cpu_en;
            n_per += per_en;
            n_osc += osc_out;
        end
        check("osc_run", osc_run, !pdn);
        check("cpu_clk", n_cpu, (idle || pdn) ? 0 : 64 / (2 * OSC_CLK));
        check("periph_clk", n_per, pdn ? 0 : 64 / (2 * OSC_CLK));
        if (!pdn) check("osc_out", n_osc, 32);
    endtask

    initial begin
        #100000;
        errors++;
        stop_test();
    end

    initial begin
        nrst = 1'b0;
        {reset_pin, sfr_wr, irq_enabled, sfr_addr, sfr_wdata} = '0;
        {port1_latch, port3_latch} = '0;
        addr_hi = 8'ha5;
        port_hi_latch = 8'h3c;
        ext_code = 1'b1;
        ext_access = 1'b1;
        repeat (12) @(negedge clk);
        check("reset_val", sfr_rdata, IPC_PWR_RESET);
        check("port_hi_rst", port_hi_out, 8'hff);
        nrst = 1'b1;
        @(negedge clk);
        for (i = 0; i < 5; i++) begin
            wr(IPC_ADDR_PWR, modes[i]);
            cmp();
            irq();
            cmp();
        end
        wr(8'h86, 8'h8f);
        cmp();
        $display("test modes done");
        for (i = 0; i < 12; i++) begin
            ext_code = 1'($random(seed));
            port_hi_latch = 8'($random(seed));
            wr(IPC_ADDR_PWR, 8'($random(seed)) & IPC_WR_MASK);
            cmp();
            irq();
        end
        $display("test random done");
        port1_latch = 8'hff;
        port3_latch = 8'hff;
        n_cpu = 0;
        n_per = 0;
        repeat (60) begin
            @(negedge clk);
            n_cpu += pu1[0];
            n_per += pu3[7];
        end
        check("pullup_len", n_cpu >= OSC_CLK * IPC_PULLUP_OSC - 2, 1);
        check("pullup_max", n_cpu <= OSC_CLK * IPC_PULLUP_OSC + 2, 1);
        check("pullup_p3", n_per, n_cpu);
        check("pullup_end", pu1, 8'h00);
        check("pullup_addr", pu2, addr_hi);
        $display("test pullup done");
        wr(IPC_ADDR_PWR, 8'h0d);
        reset_pin = 1'b1;
        repeat (160) @(negedge clk);
        check("reset_early", core_reset, 1'b0);
        repeat (60) @(negedge clk);
        check("reset_done", core_reset, 1'b1);
        check("reset_reg", sfr_rdata, IPC_PWR_RESET);
        check("reset_idle", in_idle, 1'b0);
        reset_pin = 1'b0;
        pwr = 0;
        repeat (40) @(negedge clk);
        check("reset_off", core_reset, 1'b0);
        cmp();
        $display("test pin reset done");
        stop_test();
    end
endmodule
`default_nettype wire
